// ===== pkg/hscfg_params.svh
// constants for the hub string-length and speed configuration registers
// assumes byte-wide register access from the hub's configuration port
`ifndef HSCFG_PARAMS_SVH
`define HSCFG_PARAMS_SVH
`define HSCFG_ADDR_PROD_LEN   8'h24
`define HSCFG_ADDR_CFG3       8'h25
`define HSCFG_PROD_LEN_RESET  7'h00
`define HSCFG_CFG3_RESET      8'h00
`define HSCFG_LEN_MSB         6
`define HSCFG_HSONLY_BIT      4
`define HSCFG_CFG3_WMASK      8'h1f
`define HSCFG_PROD_INDEX      8'h03
`define HSCFG_SS_5G_BIT       3
`define HSCFG_SS_5G_MASK      16'h0008
`define HSCFG_PROD_LEN_MAX    7'h40
`define HSCFG_RD_RESET        8'h00
`endif

// ===== pkg/hscfg_pkg.sv
// types for the hub string-length and speed configuration registers
// assumes nothing beyond a single core clock domain
package hscfg_pkg;
	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} hscfg_wr_type;
	typedef struct packed {
		logic       ss_enable;
		logic [15:0] speeds_supported;
	} hscfg_speed_type;
endpackage : hscfg_pkg

// ===== logic/hscfg_regs.sv
// product string length and device configuration three registers
// assumes writes come from the eeprom loader or smbus slave, one per cycle
// read data is registered and trails the read address by one cycle
`include "hscfg_params.svh"

module hscfg_regs
	import hscfg_pkg::*;
(
	input  wire logic            clock,
	input  wire logic            srst,
	input  wire hscfg_wr_type    cfg_wr,
	input  wire logic [7:0]      rd_addr,
	output logic      [7:0]      rd_data,
	input  wire logic            custom_strings_enable,
	input  wire logic            fuse_high_speed_only,
	input  wire logic            str_req,
	input  wire logic [7:0]      str_index,
	output logic                 prod_str_valid,
	output logic      [6:0]      prod_str_bytes,
	input  wire logic [15:0]     speeds_in,
	output hscfg_speed_type      speed_cap
);
	logic [6:0] prod_len_r;
	logic [6:0] prod_len_nxt;
	logic [4:0] cfg3_r;
	logic [4:0] cfg3_nxt;
	logic       high_speed_only_report;
	logic [1:0] wr_sel;
	logic [1:0] rd_sel;
	logic       prod_hit;
	logic       cfg3_hit;
	logic [7:0] rd_data_nxt;
	logic [7:0] rd_data_r;
	logic       prod_req;
	logic       str_valid_r;
	logic [6:0] str_bytes_r;
	hscfg_speed_type speed_r;
	hscfg_speed_type speed_nxt;

	// one-hot register select, shared by the write and read decoders
	function automatic logic [1:0] reg_select(logic [7:0] a);
		logic [1:0] sel;
		sel = 2'b00;
		if (a == `HSCFG_ADDR_PROD_LEN) begin
			sel = 2'b01;
		end else if (a == `HSCFG_ADDR_CFG3) begin
			sel = 2'b10;
		end
		return sel;
	endfunction : reg_select

	assign wr_sel   = reg_select(cfg_wr.addr);
	assign rd_sel   = reg_select(rd_addr);
	assign prod_hit = cfg_wr.wr && wr_sel[0];
	assign cfg3_hit = cfg_wr.wr && wr_sel[1];
	// length keeps bits 6:0, bit 7 dropped; config three keeps bits 4:0, bits 7:5 dropped
	assign prod_len_nxt = (prod_hit && custom_strings_enable) ?
		cfg_wr.wdata[`HSCFG_LEN_MSB:0] : prod_len_r;
	assign cfg3_nxt = cfg3_hit ?
		5'(cfg_wr.wdata & `HSCFG_CFG3_WMASK) : cfg3_r;
	assign high_speed_only_report =
		cfg3_r[`HSCFG_HSONLY_BIT] | fuse_high_speed_only;

	always_ff @(posedge clock) begin
		if (srst) begin
			prod_len_r <= `HSCFG_PROD_LEN_RESET;
			cfg3_r     <= 5'(`HSCFG_CFG3_RESET);
		end else begin
			prod_len_r <= prod_len_nxt;
			cfg3_r     <= cfg3_nxt;
		end
	end

	always_comb begin
		if (rd_sel[0]) begin
			rd_data_nxt = {1'b0, prod_len_r};
		end else if (rd_sel[1]) begin
			rd_data_nxt = {3'b000, high_speed_only_report, cfg3_r[3:0]};
		end else begin
			rd_data_nxt = `HSCFG_RD_RESET;
		end
	end

	// one cycle of read latency traded for a glitch-free data output
	always_ff @(posedge clock) begin
		if (srst) begin
			rd_data_r <= `HSCFG_RD_RESET;
		end else begin
			rd_data_r <= rd_data_nxt;
		end
	end
	assign rd_data = rd_data_r;

	// length trusted, no clamp at 64
	assign prod_req = str_req && str_index == `HSCFG_PROD_INDEX;
	always_ff @(posedge clock) begin
		if (srst) begin
			str_valid_r <= 1'b0;
			str_bytes_r <= 7'h00;
		end else begin
			str_valid_r <= prod_req && prod_len_r != 7'h00;
			str_bytes_r <= prod_req ? prod_len_r : 7'h00;
		end
	end
	assign prod_str_valid = str_valid_r;
	assign prod_str_bytes = str_bytes_r;

	// registered so descriptor logic sees one coherent capability copy
	// clear 5 Gbps support
	always_comb begin
		speed_nxt.speeds_supported = speeds_in;
		speed_nxt.ss_enable        = ~high_speed_only_report;
		if (high_speed_only_report) begin
			speed_nxt.speeds_supported[`HSCFG_SS_5G_BIT] = 1'b0;
		end
	end
	always_ff @(posedge clock) begin
		if (srst) begin
			speed_r <= '0;
		end else begin
			speed_r <= speed_nxt;
		end
	end
	assign speed_cap = speed_r;

	AST_LEN_LOCKED: assert property (@(posedge clock) disable iff (srst)
		prod_hit && !custom_strings_enable |=> $stable(prod_len_r))
		else $error("length changed while custom strings off");
	AST_LEN_WRITE: assert property (@(posedge clock) disable iff (srst)
		prod_hit && custom_strings_enable |=>
		prod_len_r == $past(cfg_wr.wdata[6:0]))
		else $error("length write lost");

	// read checks look one cycle on, as the read data is registered
	AST_RES_CFG3: assert property (@(posedge clock) disable iff (srst)
		rd_sel[1] |=> rd_data[7:5] == 3'b000)
		else $error("reserved bits nonzero");
	AST_RES_PROD: assert property (@(posedge clock) disable iff (srst)
		rd_sel[0] |=> !rd_data[7])
		else $error("product reserved bit nonzero");
	AST_OR_READ: assert property (@(posedge clock) disable iff (srst)
		rd_sel[1] && fuse_high_speed_only |=> rd_data[4])
		else $error("fuse not reflected");
	AST_RESET: assert property (@(posedge clock)
		srst |=> cfg3_r == 5'h00 && prod_len_r == 7'h00)
		else $error("reset values wrong");
	AST_ZERO_LEN: assert property (@(posedge clock) disable iff (srst)
		prod_req && prod_len_r == 7'h00 |=> !prod_str_valid)
		else $error("string offered with zero length");
	AST_STR_LEN: assert property (@(posedge clock) disable iff (srst)
		prod_req && prod_len_r != 7'h00 |=>
		prod_str_valid && prod_str_bytes == $past(prod_len_r))
		else $error("string length mismatch");
	AST_NO_5G: assert property (@(posedge clock) disable iff (srst)
		high_speed_only_report |=> !speed_cap.speeds_supported[3])
		else $error("5 Gbps still reported");
	AST_SS_OFF: assert property (@(posedge clock) disable iff (srst)
		high_speed_only_report |=> !speed_cap.ss_enable)
		else $error("superspeed still enabled");

	// capability passes through untouched when the feature is off
	AST_SS_ON: assert property (@(posedge clock) disable iff (srst)
		!high_speed_only_report |=> speed_cap.ss_enable &&
		speed_cap.speeds_supported == $past(speeds_in))
		else $error("speed capability not passed through");
	AST_SPEED_KEEP: assert property (@(posedge clock) disable iff (srst)
		high_speed_only_report |=>
		(speed_cap.speeds_supported | `HSCFG_SS_5G_MASK) ==
		($past(speeds_in) | `HSCFG_SS_5G_MASK))
		else $error("speed bits other than 5 Gbps disturbed");

	// registers move only on an accepted write
	AST_CFG3_WRITE: assert property (@(posedge clock) disable iff (srst)
		cfg3_hit |=> cfg3_r == $past(cfg_wr.wdata[4:0]))
		else $error("config three write lost");
	AST_CFG3_HOLD: assert property (@(posedge clock) disable iff (srst)
		!cfg3_hit |=> $stable(cfg3_r))
		else $error("config three changed without a write");
	AST_PROD_HOLD: assert property (@(posedge clock) disable iff (srst)
		!prod_hit |=> $stable(prod_len_r))
		else $error("length changed without a write");

	// read path contents
	AST_PROD_READ: assert property (@(posedge clock) disable iff (srst)
		rd_sel[0] |=> rd_data == {1'b0, $past(prod_len_r)})
		else $error("length read back wrong");
	AST_UNMAPPED: assert property (@(posedge clock) disable iff (srst)
		rd_sel == 2'b00 |=> rd_data == `HSCFG_RD_RESET)
		else $error("unmapped read not zero");

	// no string answer may appear without its request
	AST_STR_IDLE: assert property (@(posedge clock) disable iff (srst)
		!prod_req |=> !prod_str_valid && prod_str_bytes == 7'h00)
		else $error("string answer without a request");

	COV_LEN_WRITE: cover property (@(posedge clock)
		prod_hit && custom_strings_enable);
	COV_STR: cover property (@(posedge clock) prod_req ##1 prod_str_valid);
	COV_HSONLY: cover property (@(posedge clock) cfg3_hit ##1 cfg3_r[4]);
	// fuse alone must be enough to drop superspeed
	COV_FUSE_ONLY: cover property (@(posedge clock)
		(fuse_high_speed_only && !cfg3_r[4]) ##1 !speed_cap.ss_enable);
	COV_LEN_LOCKED: cover property (@(posedge clock)
		prod_hit && !custom_strings_enable);
endmodule : hscfg_regs

// ===== dv/hscfg_loader.sv
// config loader model, eeprom or smbus host
// assumes requests change at the falling clock edge
`include "hscfg_params.svh"
module hscfg_loader
	import hscfg_pkg::*;
(
	input  wire logic       req,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] data,
	output hscfg_wr_type    cfg_wr
);
	timeunit 1ns;
	timeprecision 1ps;
	wire logic too_long = (addr == `HSCFG_ADDR_PROD_LEN) &&
		(data[6:0] > `HSCFG_PROD_LEN_MAX);
	// idle data inverted so stale values never look valid
	assign cfg_wr = '{req && !too_long, addr, req ? data : ~data};
endmodule : hscfg_loader

// ===== dv/hscfg_regs_tb.sv
// bench for product length and config three
// assumes the loader model and the register block
`include "hscfg_params.svh"
module hscfg_regs_tb
	import hscfg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic            clock = 0, srst = 1, req = 0, cse = 0, fuse = 0;
	logic            sreq = 0, valid;
	logic [7:0]      addr = 0, data = 0, rd_addr = 0, sidx = 0, rd_data;
	logic [6:0]      bytes;
	logic [15:0]     speeds = 16'h000e;
	hscfg_wr_type    cfg_wr;
	hscfg_speed_type cap;
	int              errors = 0, compares = 0;
	always #4 clock = ~clock;
	hscfg_loader u_loader (.req(req), .addr(addr), .data(data),
		.cfg_wr(cfg_wr));
	hscfg_regs u_dut (.clock(clock), .srst(srst), .cfg_wr(cfg_wr),
		.rd_addr(rd_addr), .rd_data(rd_data), .custom_strings_enable(cse),
		.fuse_high_speed_only(fuse), .str_req(sreq), .str_index(sidx),
		.prod_str_valid(valid), .prod_str_bytes(bytes),
		.speeds_in(speeds), .speed_cap(cap));
	task automatic chk(string n, logic [16:0] e, logic [16:0] g);
		compares++;
		if (g !== e) begin
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
			errors++;
		end
	endtask : chk
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(negedge clock) {req, addr, data} = {1'b1, a, d};
		@(negedge clock) req = 0;
	endtask : wr
	task automatic rd(logic [7:0] a, logic [7:0] e);
		@(negedge clock) rd_addr = a;
		@(negedge clock) chk("rd_data", {9'h0, e}, {9'h0, rd_data});
	endtask : rd
	// e packs the valid pulse over the byte count
	task automatic st(logic [7:0] i, logic [7:0] e);
		@(negedge clock) {sreq, sidx} = {1'b1, i};
		@(negedge clock) sreq = 0;
		chk("string", {9'h0, e}, {9'h0, valid, bytes});
	endtask : st
	task automatic tally_and_finish();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (12) @(negedge clock);
		srst = 0;
		rd(`HSCFG_ADDR_PROD_LEN, 8'h00);
		rd(`HSCFG_ADDR_CFG3, 8'h00);
		chk("speed_cap", {1'b1, 16'h000e}, cap);
		st(8'h03, 8'h00);
		$display("reset test ends");
		wr(`HSCFG_ADDR_PROD_LEN, 8'h12);
		rd(`HSCFG_ADDR_PROD_LEN, 8'h00);
		cse = 1;
		wr(`HSCFG_ADDR_PROD_LEN, 8'hc0);
		rd(`HSCFG_ADDR_PROD_LEN, 8'h40);
		st(8'h03, 8'hc0);
		st(8'h02, 8'h00);
		wr(`HSCFG_ADDR_PROD_LEN, 8'h41);
		rd(`HSCFG_ADDR_PROD_LEN, 8'h40);
		$display("length test ends");
		wr(`HSCFG_ADDR_CFG3, 8'hef);
		rd(`HSCFG_ADDR_CFG3, 8'h0f);
		chk("speed_cap", {1'b1, 16'h000e}, cap);
		wr(`HSCFG_ADDR_CFG3, 8'hf0);
		rd(`HSCFG_ADDR_CFG3, 8'h10);
		chk("speed_cap", {1'b0, 16'h0006}, cap);
		wr(`HSCFG_ADDR_CFG3, 8'h00);
		fuse = 1;
		rd(`HSCFG_ADDR_CFG3, 8'h10);
		chk("speed_cap", {1'b0, 16'h0006}, cap);
		$display("config three test ends");
		@(negedge clock) srst = 1;
		repeat (2) @(negedge clock);
		srst = 0;
		rd(`HSCFG_ADDR_PROD_LEN, 8'h00);
		rd(`HSCFG_ADDR_CFG3, 8'h10);
		chk("speed_cap", {1'b0, 16'h0006}, cap);
		fuse = 0;
		speeds = 16'h000a;
		rd(`HSCFG_ADDR_CFG3, 8'h00);
		chk("speed_cap", {1'b1, 16'h000a}, cap);
		$display("mid-run reset test ends");
		tally_and_finish();
	end
	initial begin
		#20000;
		errors++;
		tally_and_finish();
	end
endmodule : hscfg_regs_tb
